//--- hdl/uie_pkg.sv
// constants, types and register map of the usb interrupt enable and frame register bank
package uie_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [11:0] IDX_STATUS = 12'h00A;
  localparam logic [11:0] IDX_ENABLE = 12'h00B;
  localparam logic [11:0] IDX_FRAME = 12'h00C;
  localparam logic [11:0] IDX_CLEAR = 12'h010;
  localparam int unsigned IDX_W = 12;
  localparam int unsigned ADDR_LSB = 2;

  // field layout shared by status, enable and clear
  localparam int unsigned BIT_SLEEP = 0;
  localparam int unsigned BIT_RESUME = 1;
  localparam int unsigned BIT_BUS_EVT = 2;
  localparam int unsigned BIT_SOF = 3;
  localparam int unsigned BIT_ATTACH = 4;
  localparam int unsigned BIT_DETACH = 5;
  localparam int unsigned EVT_W = 6;

  localparam logic [7:0] ENABLE_RST = 8'h06;
  localparam logic [7:0] ENABLE_MASK = 8'h3F;
  localparam logic [7:0] STATUS_RST = 8'h00;
  // in host mode bit 0 has no source, in device mode bit 4 has none
  localparam logic [5:0] HOST_VALID = 6'h3E;
  localparam logic [5:0] DEV_VALID = 6'h2F;

  localparam int unsigned FRAME_W = 11;
  localparam logic [15:0] FRAME_RST = 16'h0000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  typedef struct packed {
    logic detach;
    logic attach;
    logic sof;
    logic bus_evt;
    logic resume;
    logic sleep;
  } uie_event_type;

  typedef enum logic [1:0] {
    APB_IDLE = 2'h0,
    APB_ACCESS = 2'h1
  } uie_apb_state_type;

endpackage

//--- hdl/uie_status.sv
// sticky interrupt status flags with read-clear and write-clear
module uie_status (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic host_mode,
  input wire logic [5:0] event_set,
  input wire logic [5:0] rd_clr,
  input wire logic [5:0] wr_clr,
  output logic [5:0] status_ff
);

  logic [5:0] valid;
  logic [5:0] nxt_status;

  always_comb begin
    valid = host_mode ? uie_pkg::HOST_VALID : uie_pkg::DEV_VALID;
    // set wins over clear so an event in the clearing cycle survives
    nxt_status = (status_ff & ~(rd_clr | wr_clr)) | (event_set & valid);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      status_ff <= uie_pkg::STATUS_RST[5:0];
    end else begin
      status_ff <= nxt_status;
    end
  end

endmodule

//--- hdl/uie_top.sv
// apb register bank: interrupt enable, interrupt status, clear and last frame number
//
// Behaviour
// - eight-bit read/write interrupt enable register at index 0x00B masks status bits.
// - enable register resets to 0x06, bits 1 and 2 set, both modes.
// - enable bit 5 lets session-disconnect status raise the interrupt.
// - enable bit 4 lets session-connect status raise the interrupt; resets zero.
// - enable bit 3 lets start-of-frame status raise the interrupt; resets zero.
// - host mode: enable bit 2 gates bus-reset status, resets to one.
// - device mode: enable bit 2 gates babble status, resets to one.
// - enable bit 1 gates resume status; resets to one.
// - enable bit 0 gates suspend status; resets to zero.
// - enable bits 7:6 read zero; software keeps them on read-modify-write.
// - sixteen-bit read-only frame register at index 0x00C, resets zero, writes ignored.
// - frame register shows last frame number in bits 10:0, zero above.
// - reading the status register clears only the flags it returned; flags set after the read data was captured stay set.
//
// The APB interface to the registers was chosen for this implementation.
module uie_top #(
  parameter int unsigned ADDR_W = 16
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic host_mode,
  input wire uie_pkg::uie_event_type events,
  input wire logic frame_strobe,
  input wire logic [10:0] frame_num,
  output logic irq
);

  uie_pkg::uie_apb_state_type state_ff;
  uie_pkg::uie_apb_state_type nxt_state;
  logic [7:0] enable_ff;
  logic [uie_pkg::FRAME_W-1:0] frame_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_ff;
  logic [5:0] status_ff;
  logic [5:0] rd_clr;
  logic [5:0] wr_clr;
  logic [31:0] rd_value;
  logic mapped;
  logic done;
  logic wr_done;
  logic rd_done;

  // index decode; addresses off the word grid do not match any register
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [11:0] idx);
    logic [ADDR_W-1:0] base;
    base = ADDR_W'({idx, 2'h0});
    return addr == base;
  endfunction

  // the transfer completes at the edge where pready is high in the access phase
  assign done = psel && penable && pready_ff;
  assign wr_done = done && pwrite;
  assign rd_done = done && !pwrite;

  always_comb begin
    mapped = hit(paddr, uie_pkg::IDX_STATUS) || hit(paddr, uie_pkg::IDX_ENABLE) ||
             hit(paddr, uie_pkg::IDX_FRAME) || hit(paddr, uie_pkg::IDX_CLEAR);
  end

  always_comb begin
    rd_value = uie_pkg::RDATA_RST;
    if (hit(paddr, uie_pkg::IDX_STATUS)) begin
      rd_value = {24'h00_0000, 2'h0, status_ff};
    end else if (hit(paddr, uie_pkg::IDX_ENABLE)) begin
      rd_value = {24'h00_0000, enable_ff & uie_pkg::ENABLE_MASK};
    end else if (hit(paddr, uie_pkg::IDX_FRAME)) begin
      rd_value = {16'h0000, 5'h00, frame_ff};
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      uie_pkg::APB_IDLE: begin
        if (psel && penable) begin
          nxt_state = uie_pkg::APB_ACCESS;
        end
      end
      uie_pkg::APB_ACCESS: begin
        nxt_state = uie_pkg::APB_IDLE;
      end
      default: begin
        nxt_state = uie_pkg::APB_IDLE;
      end
    endcase
  end

  // one wait state: read data is captured a cycle before completion
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= uie_pkg::APB_IDLE;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= uie_pkg::RDATA_RST;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == uie_pkg::APB_IDLE && psel && penable) begin
        pready_ff <= 1'b1;
        pslverr_ff <= !mapped;
        prdata_ff <= pwrite ? uie_pkg::RDATA_RST : rd_value;
      end else begin
        pready_ff <= 1'b0;
        pslverr_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      enable_ff <= uie_pkg::ENABLE_RST;
    end else if (wr_done && hit(paddr, uie_pkg::IDX_ENABLE)) begin
      // bits 5..0 map detach, attach, sof, bus reset or babble, resume, sleep
      enable_ff <= pwdata[7:0] & uie_pkg::ENABLE_MASK;
    end
  end

  // writes to the frame index fall through: it has no write path
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      frame_ff <= uie_pkg::FRAME_RST[uie_pkg::FRAME_W-1:0];
    end else if (frame_strobe) begin
      frame_ff <= frame_num;
    end
  end

  // a status read clears only the flags shown to software; a clear write clears the bits written; later events stay set
  always_comb begin
    rd_clr = (rd_done && hit(paddr, uie_pkg::IDX_STATUS)) ? prdata_ff[5:0] : 6'h00;
    wr_clr = (wr_done && hit(paddr, uie_pkg::IDX_CLEAR)) ? pwdata[5:0] : 6'h00;
  end

  uie_status u_status (
    .mclk(mclk),
    .arst_n(arst_n),
    .host_mode(host_mode),
    .event_set(events),
    .rd_clr(rd_clr),
    .wr_clr(wr_clr),
    .status_ff(status_ff)
  );

  // registered, so the request trails the status and enable by one cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(status_ff & enable_ff[5:0]);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;

endmodule

//--- tb/uie_top_asserts.sv
// port-level assertions for the interrupt enable and frame register bank
module uie_top_asserts (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_req;
    psel && !penable ##1 psel && penable;
  endsequence
  a_one_wait: assert property (s_req |-> !pready ##1 pready) else $error("ready not after one wait");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
  a_ready_phase: assert property (pready |-> psel && penable) else $error("ready outside access");
  a_err_map: assert property (pready |-> pslverr == !(paddr inside {16'h0028, 16'h002C, 16'h0030,
    16'h0040})) else $error("error flag wrong for address");
  a_err_pulse: assert property (pslverr |-> pready) else $error("error without ready");
  a_enable_upper: assert property (pready && !pwrite && paddr == 16'h002C |-> prdata[31:6] == 26'h0)
    else $error("enable upper bits set");
  a_frame_upper: assert property (pready && !pwrite && paddr == 16'h0030 |-> prdata[31:11] == 21'h0)
    else $error("frame upper bits set");
  // irq may only drop after a completed access (read-clear, clear or enable write)
  a_irq_fall: assert property ($fell(irq) |-> $past(pready, 2) || $past(pready, 3))
    else $error("irq dropped without access");
endmodule

bind uie_top uie_top_asserts u_chk (.mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .irq);

//--- tb/usb_irq_enable_and_frame_regs_tb.sv
// self-checking bench for the interrupt enable and frame register bank
module usb_irq_enable_and_frame_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic w; logic [15:0] a; logic [31:0] d; logic [31:0] x; logic err;} uie_row_type;
  logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, host_mode, frame_strobe, irq, e;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [10:0] frame_num;
  uie_pkg::uie_event_type events;
  int bad_count, num_checks;
  uie_row_type rows [8] = '{'{1'h1, 16'h002C, 32'hFFFFFFFF, 32'h0, 1'h0},
    '{1'h0, 16'h002C, 32'h0, 32'h3F, 1'h0}, '{1'h1, 16'h0030, 32'hFFFFFFFF, 32'h0, 1'h0},
    '{1'h0, 16'h0030, 32'h0, 32'h0, 1'h0}, '{1'h0, 16'h0050, 32'h0, 32'h0, 1'h1},
    '{1'h1, 16'h0050, 32'h0, 32'h0, 1'h1}, '{1'h1, 16'h002C, 32'h0, 32'h0, 1'h0},
    '{1'h0, 16'h002C, 32'h0, 32'h0, 1'h0}};
  uie_top DUT (.mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .host_mode, .events, .frame_strobe, .frame_num, .irq);
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check_val(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      bad_count++;
      $display("Error %0t got %h want %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'h0; penable <= 1'h0;
    @(posedge mclk);
    if (n >= 16) begin
      bad_count++;
      $display("Error %0t bus timeout", $time);
      stop_test;
    end
  endtask
  task automatic pulse(input logic [5:0] v);
    events <= uie_pkg::uie_event_type'(v);
    @(posedge mclk);
    events <= '0;
    repeat (2) @(posedge mclk);
  endtask
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    {arst_n, psel, penable, pwrite, host_mode, frame_strobe} = 6'h0;
    paddr = 16'h0; pwdata = 32'h0; events = '0; frame_num = 11'h0; bad_count = 0; num_checks = 0;
    repeat (20) @(posedge mclk);
    arst_n <= 1'h1;
    @(posedge mclk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) check_val(r, rows[i].x);
      check_val({31'h0, e}, {31'h0, rows[i].err});
    end
    for (int b = 0; b < 6; b++) begin
      host_mode <= (b > 2);
      apb(1'h1, 16'h002C, 32'h1 << b);
      apb(1'h1, 16'h0040, 32'h3F);
      pulse(6'h01 << b);
      check_val({31'h0, irq}, 32'h1);
      apb(1'h0, 16'h0028, 32'h0);
      check_val(r, 32'h1 << b);
      repeat (2) @(posedge mclk);
      check_val({31'h0, irq}, 32'h0);
    end
    // host layout: bit 2 is the bus-reset flag and its enable must still raise the request
    apb(1'h1, 16'h002C, 32'h04);
    pulse(6'h04);
    check_val({31'h0, irq}, 32'h1);
    apb(1'h0, 16'h0028, 32'h0);
    check_val(r, 32'h04);
    // masked events still latch; host layout has no source on bit 0
    apb(1'h1, 16'h002C, 32'h0);
    pulse(6'h3F);
    check_val({31'h0, irq}, 32'h0);
    apb(1'h1, 16'h0040, 32'h0F);
    apb(1'h0, 16'h0028, 32'h0);
    check_val(r, 32'h30);
    apb(1'h0, 16'h0028, 32'h0);
    check_val(r, 32'h0);
    // device layout has no source on bit 4
    host_mode <= 1'h0;
    pulse(6'h3F);
    apb(1'h0, 16'h0028, 32'h0);
    check_val(r, 32'h2F);
    frame_num <= 11'h7FF; frame_strobe <= 1'h1;
    @(posedge mclk);
    frame_strobe <= 1'h0;
    apb(1'h1, 16'h0030, 32'h0);
    apb(1'h0, 16'h0030, 32'h0);
    check_val(r, 32'h7FF);
    arst_n <= 1'h0;
    repeat (20) @(posedge mclk);
    arst_n <= 1'h1;
    @(posedge mclk);
    apb(1'h0, 16'h002C, 32'h0);
    check_val(r, 32'h06);
    // read-modify-write keeps whatever the reserved bits returned
    apb(1'h1, 16'h002C, r | 32'h20);
    apb(1'h0, 16'h002C, 32'h0);
    check_val(r, 32'h26);
    apb(1'h0, 16'h0030, 32'h0);
    check_val(r, 32'h0);
    stop_test;
  end
endmodule
